// *** frequency_edge_trigger.sv ***
// frequency edge trigger with interpolated timing path
//
// How it works
// (R01) fire each time measured frequency crosses the trigger level
// (R02) trigger level is hertz offset from center frequency
// (R03) level clamped to half acquisition or half resolution bandwidth
// (R04) instantaneous frequency computed and compared on every sample
// (R05) no trigger while sample power is below power threshold
// (R06) fire only after passing hysteresis level then trigger level
// (R07) hysteresis is two percent of full trigger bandwidth
// (R08) hysteresis recomputed whenever bandwidth changes
// (R09) trigger filter bandwidth equals display resolution bandwidth when rbw enabled, else acquisition bandwidth
// (R10) current hysteresis value offered as readout
// (R11) fastest sweep 100 ns, 801 points, needs 64-fold interpolation
// (R12) samples go into a fifo, read slower and interpolated
// (R13) trigger and display share one decimated sample stream
// (R14) default trigger timing is one decimated sample
// (R15) matching display type gives trigger timed to one interpolated step
// (R16) interpolated trigger only to time-domain displays
// (R17) trigger runs alongside time-domain display without stopping it
// (R18) hysteresis below level rising, above falling; re-arm past it
`include "frequency_edge_trigger_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module frequency_edge_trigger (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_smp_valid,
	input wire logic signed [`FET_SMP_W-1:0] i_smp_i,
	input wire logic signed [`FET_SMP_W-1:0] i_smp_q,
	input wire logic signed [`FET_HZ_W-1:0] i_level_hz,
	input wire logic i_slope_fall,
	input wire logic [`FET_ACC_W-1:0] i_pwr_thresh,
	input wire logic [`FET_HZ_W-1:0] i_hz_scale,
	input wire logic [`FET_HZ_W-1:0] i_acq_bw_hz,
	input wire logic i_rbw_en,
	input wire logic [`FET_HZ_W-1:0] i_rbw_hz,
	input wire logic i_interp_en,
	input wire logic i_td_match,
	output logic o_trig_dec,
	output logic o_trig_td,
	output logic [`FET_STEP_W-1:0] o_trig_frac,
	output logic [`FET_HZ_W-1:0] o_hyst_hz,
	output logic signed [`FET_HZ_W-1:0] o_level_hz,
	output logic [`FET_HZ_W-1:0] o_trigger_filter_bandwidth,
	output logic o_pwr_low,
	output logic o_armed,
	output logic o_interp_valid,
	output logic signed [`FET_ACC_W-1:0] o_interp_d,
	output logic signed [`FET_ACC_W-1:0] o_interp_p,
	output logic o_fifo_ovf
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic signed [`FET_SMP_W-1:0] pi;
		logic signed [`FET_SMP_W-1:0] pq;
		logic have_prev;
		fet_pkg::arm_t arm_dec;
		fet_pkg::arm_t arm_int;
		logic signed [`FET_HZ_W-1:0] lvl;
		logic [`FET_HZ_W-1:0] hyst;
		logic [`FET_HZ_W-1:0] bw;
		logic trig_dec;
		logic trig_td;
		logic pwr_low;
		logic ovf;
		logic ivalid;
		logic [`FET_STEP_W-1:0] frac;
		logic [`FET_STEP_W-1:0] k;
		logic [`FET_FIFO_DEPTH-1:0][2*`FET_ACC_W-1:0] fifo;
		logic [`FET_PTR_W-1:0] wp;
		logic [`FET_PTR_W-1:0] rp;
		logic signed [`FET_ACC_W-1:0] id;
		logic signed [`FET_ACC_W-1:0] ip;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// ------------------------------------------------------------
	// arithmetic helpers
	// ------------------------------------------------------------
	// freq >= level, done as cross multiply: no divider in the path
	function automatic logic hz_ge(
		input logic signed [`FET_ACC_W-1:0] d,
		input logic [`FET_HZ_W-1:0] sc,
		input logic signed [`FET_ACC_W-1:0] l,
		input logic signed [`FET_ACC_W-1:0] p
	);
		logic signed [`FET_PROD_W-1:0] lhs;
		logic signed [`FET_PROD_W-1:0] rhs;
		lhs = d * $signed({1'b0, sc});
		rhs = l * p;
		hz_ge = (lhs >= rhs);
	endfunction

	// returns {fire, armed_next}
	function automatic logic [1:0] edge_step(
		input fet_pkg::arm_t a,
		input logic signed [`FET_ACC_W-1:0] d,
		input logic signed [`FET_ACC_W-1:0] p,
		input logic signed [`FET_ACC_W-1:0] lv,
		input logic signed [`FET_ACC_W-1:0] hy,
		input logic [`FET_HZ_W-1:0] sc,
		input logic fall,
		input logic [`FET_ACC_W-1:0] thr
	);
		logic signed [`FET_ACC_W-1:0] sd;
		logic signed [`FET_ACC_W-1:0] sl;
		logic at_lvl;
		logic past_hy;
		// falling edge mirrored: negate both sides of the compare
		sd = fall ? -d : d; // see (R18)
		sl = fall ? -lv : lv;
		at_lvl = hz_ge(sd, sc, sl, p); // see (R01)
		past_hy = !hz_ge(sd, sc, sl - hy, p); // see (R06)
		if ($unsigned(p) < thr) begin
			edge_step = 2'b00; // see (R05)
		end else if (a == fet_pkg::ST_ARMED && at_lvl) begin
			edge_step = 2'b10; // see (R06)
		end else if (past_hy) begin
			edge_step = 2'b01; // see (R18)
		end else begin
			edge_step = {1'b0, a == fet_pkg::ST_ARMED};
		end
	endfunction

	function automatic logic signed [`FET_ACC_W-1:0] lerp(
		input logic signed [`FET_ACC_W-1:0] a,
		input logic signed [`FET_ACC_W-1:0] b,
		input logic [`FET_STEP_W-1:0] k
	);
		logic [`FET_STEP_W:0] wa;
		logic signed [`FET_LERP_W-1:0] s;
		wa = (`FET_STEP_W+1)'(`FET_INTERP_STEPS) - {1'b0, k};
		s = a * $signed({1'b0, wa}) + b * $signed({2'b0, k});
		lerp = s[`FET_ACC_W+`FET_STEP_W-1:`FET_STEP_W];
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic [`FET_HZ_W-1:0] bw_c;
	logic [`FET_HZ_W-1:0] half_c;
	logic signed [`FET_ACC_W-1:0] lvl_c;
	logic signed [`FET_ACC_W-1:0] hy_c;
	logic signed [`FET_ACC_W-1:0] lv_c;
	logic signed [`FET_ACC_W-1:0] d_c;
	logic signed [`FET_ACC_W-1:0] p_c;
	logic signed [`FET_ACC_W-1:0] ia;
	logic signed [`FET_ACC_W-1:0] ib;
	logic [`FET_PTR_W-1:0] cnt_c;
	logic [1:0] dec_r;
	logic [1:0] int_r;
	logic dec_fire;

	always_comb begin
		st_nxt = st_r;
		st_nxt.trig_dec = 1'b0;
		st_nxt.trig_td = 1'b0;
		st_nxt.ovf = 1'b0;
		// one shared filter: rbw also sets the trigger bandwidth
		bw_c = i_rbw_en ? i_rbw_hz : i_acq_bw_hz; // see (R03) (R09)
		half_c = bw_c >> 1;
		lvl_c = `FET_ACC_W'(i_level_hz); // see (R02)
		if (lvl_c > $signed({2'b0, half_c})) begin
			lvl_c = $signed({2'b0, half_c}); // see (R03)
		end else if (lvl_c < -$signed({2'b0, half_c})) begin
			lvl_c = -$signed({2'b0, half_c});
		end
		st_nxt.bw = bw_c;
		st_nxt.lvl = lvl_c[`FET_HZ_W-1:0];
		// recomputed every clock, so it follows any bandwidth change
		st_nxt.hyst = `FET_HZ_W'(({1'b0, bw_c} * `FET_HYST_PCT)
			/ `FET_PCT_BASE); // see (R07) (R08) (R10)
		hy_c = $signed({2'b0, st_r.hyst});
		lv_c = `FET_ACC_W'($signed(st_r.lvl));
		// phase-difference discriminator on the shared stream
		d_c = st_r.pi * i_smp_q - st_r.pq * i_smp_i; // see (R04) (R13)
		p_c = i_smp_i * i_smp_i + i_smp_q * i_smp_q;
		dec_r = edge_step(st_r.arm_dec, d_c, p_c, lv_c, hy_c,
			i_hz_scale, i_slope_fall, i_pwr_thresh);
		dec_fire = 1'b0;
		cnt_c = st_r.wp - st_r.rp;
		if (i_smp_valid) begin
			st_nxt.pi = i_smp_i;
			st_nxt.pq = i_smp_q;
			st_nxt.have_prev = 1'b1;
			if (st_r.have_prev) begin
				dec_fire = dec_r[1]; // see (R14)
				st_nxt.arm_dec = dec_r[0] ? fet_pkg::ST_ARMED
					: fet_pkg::ST_WAIT;
				st_nxt.pwr_low = ($unsigned(p_c) < i_pwr_thresh);
				if (i_interp_en) begin
					if (cnt_c != `FET_PTR_W'(`FET_FIFO_DEPTH)) begin
						st_nxt.fifo[st_r.wp[`FET_IDX_W-1:0]] =
							{d_c, p_c}; // see (R12)
						st_nxt.wp = st_r.wp + 1'b1;
					end else begin
						// burst longer than the fifo: sample lost
						st_nxt.ovf = 1'b1;
					end
				end
			end
		end
		st_nxt.trig_dec = dec_fire; // see (R16)
		// interpolation stage, independent of the decimated path
		ia = st_r.fifo[st_r.rp[`FET_IDX_W-1:0]][2*`FET_ACC_W-1:`FET_ACC_W];
		ib = st_r.fifo[st_r.rp[`FET_IDX_W-1:0] + 1'b1]
			[2*`FET_ACC_W-1:`FET_ACC_W];
		st_nxt.id = lerp(ia, ib, st_r.k); // see (R11) (R12)
		ia = st_r.fifo[st_r.rp[`FET_IDX_W-1:0]][`FET_ACC_W-1:0];
		ib = st_r.fifo[st_r.rp[`FET_IDX_W-1:0] + 1'b1][`FET_ACC_W-1:0];
		st_nxt.ip = lerp(ia, ib, st_r.k);
		int_r = edge_step(st_r.arm_int, st_nxt.id, st_nxt.ip, lv_c,
			hy_c, i_hz_scale, i_slope_fall, i_pwr_thresh);
		st_nxt.ivalid = 1'b0;
		if (!i_interp_en) begin
			st_nxt.rp = st_r.wp;
			st_nxt.k = '0;
			st_nxt.arm_int = fet_pkg::ST_WAIT;
		end else if (cnt_c >= `FET_PTR_W'(2)) begin
			// display keeps its stream whatever the trigger does
			st_nxt.ivalid = 1'b1; // see (R17)
			st_nxt.arm_int = int_r[0] ? fet_pkg::ST_ARMED
				: fet_pkg::ST_WAIT;
			st_nxt.k = st_r.k + 1'b1;
			if (st_r.k == `FET_STEP_W'(`FET_INTERP_STEPS - 1)) begin
				st_nxt.rp = st_r.rp + 1'b1;
			end
		end
		if (i_td_match) begin
			st_nxt.trig_td = i_interp_en && cnt_c >= `FET_PTR_W'(2)
				&& int_r[1]; // see (R15)
			st_nxt.frac = st_r.k;
		end else begin
			st_nxt.trig_td = dec_fire; // see (R16)
			st_nxt.frac = '0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_trig_dec = st_r.trig_dec;
	assign o_trig_td = st_r.trig_td;
	assign o_trig_frac = st_r.frac;
	assign o_hyst_hz = st_r.hyst;
	assign o_level_hz = st_r.lvl;
	assign o_trigger_filter_bandwidth = st_r.bw;
	assign o_pwr_low = st_r.pwr_low;
	assign o_armed = (st_r.arm_dec == fet_pkg::ST_ARMED);
	assign o_interp_valid = st_r.ivalid;
	assign o_interp_d = st_r.id;
	assign o_interp_p = st_r.ip;
	assign o_fifo_ovf = st_r.ovf;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	sequence s_low_pwr;
		i_smp_valid && st_r.have_prev && ($unsigned(p_c) < i_pwr_thresh);
	endsequence

	sequence s_armed;
		st_r.arm_dec == fet_pkg::ST_ARMED;
	endsequence

	a_low_pwr_gate: assert property (s_low_pwr |=> // see (R05)
		!o_trig_dec && !o_armed)
		else $error("trigger or arm under power threshold");

	a_fire_needs_arm: assert property (o_trig_dec |-> // see (R06)
		$past(st_r.arm_dec == fet_pkg::ST_ARMED))
		else $error("trigger without prior arming");

	a_no_double_fire: assert property (s_armed ##1 o_trig_dec // see (R18)
		|-> !o_armed ##1 !o_trig_dec)
		else $error("trigger repeated without re-arm");

	a_hyst_rbw: assert property (i_rbw_en |=> o_hyst_hz == // see (R07)
		`FET_HZ_W'(({1'b0, $past(i_rbw_hz)} * `FET_HYST_PCT)
		/ `FET_PCT_BASE))
		else $error("hysteresis not two percent of rbw");

	a_bw_select: assert property (!i_rbw_en |=> // see (R09)
		o_trigger_filter_bandwidth == $past(i_acq_bw_hz))
		else $error("bandwidth select wrong");

	a_level_clamp: assert property (##1 // see (R03)
		o_level_hz <= $signed({1'b0, $past(half_c)})
		&& o_level_hz >= -$signed({1'b0, $past(half_c)}))
		else $error("level beyond half bandwidth");

	a_td_route: assert property (!$past(i_td_match) // see (R16)
		|-> o_trig_td == o_trig_dec)
		else $error("time-domain trigger differs from decimated");

	a_interp_frac: assert property (o_trig_td // see (R15)
		&& $past(i_td_match) |-> o_trig_frac == $past(st_r.k))
		else $error("interpolated step not reported");

	a_fifo_bound: assert property (st_r.wp - st_r.rp // see (R12)
		<= `FET_PTR_W'(`FET_FIFO_DEPTH))
		else $error("fifo count beyond depth");

endmodule

`default_nettype wire

// *** frequency_edge_trigger_defs.svh ***
// constants of the frequency edge trigger
`ifndef FREQUENCY_EDGE_TRIGGER_DEFS_SVH
`define FREQUENCY_EDGE_TRIGGER_DEFS_SVH
`define FET_SMP_W 16
`define FET_ACC_W 34
`define FET_HZ_W 32
`define FET_PROD_W 67
`define FET_LERP_W 42
`define FET_HYST_PCT 2
`define FET_PCT_BASE 100
`define FET_CLK_PS 8000
`define FET_INTERP_PS 125
`define FET_INTERP_STEPS (`FET_CLK_PS / `FET_INTERP_PS)
`define FET_STEP_W 6
`define FET_FIFO_DEPTH 8
`define FET_PTR_W 4
`define FET_IDX_W 3
`define FET_SWEEP_NS 100
`define FET_TRACE_PTS 801
`endif

// *** fet_pkg.sv ***
// types of the frequency edge trigger
package fet_pkg;
	typedef enum logic {
		ST_WAIT,
		ST_ARMED
	} arm_t;
endpackage

// *** trig_consumer.sv ***
// model of the acquisition and display trigger consumers
`timescale 1ns/1ps
`default_nettype none

module trig_consumer (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_trig_dec,
	input wire logic i_trig_td,
	input wire logic i_interp_valid,
	output var int o_n_dec,
	output var int o_n_td,
	output var int o_n_iv
);
	// ----------------------------------------
	// pulse counters
	// ----------------------------------------
	// counting cycles high, not edges, so a stuck trigger shows as a big count
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_n_dec <= 0;
			o_n_td <= 0;
			o_n_iv <= 0;
		end else begin
			if (i_trig_dec === 1'b1) o_n_dec <= o_n_dec + 1;
			if (i_trig_td === 1'b1) o_n_td <= o_n_td + 1;
			if (i_interp_valid === 1'b1) o_n_iv <= o_n_iv + 1;
		end
	end
endmodule

`default_nettype wire

// *** frequency_edge_trigger_tb.sv ***
// self-checking bench for the frequency edge trigger
`timescale 1ns/1ps
`default_nettype none

module frequency_edge_trigger_tb;
	logic i_clk, i_rst_b, i_smp_valid, i_slope_fall, i_rbw_en;
	logic i_interp_en, i_td_match, o_trig_dec, o_trig_td;
	logic o_pwr_low, o_armed, o_interp_valid, o_fifo_ovf;
	logic [5:0] o_trig_frac;
	logic signed [33:0] o_interp_d, o_interp_p;
	logic signed [15:0] i_smp_i, i_smp_q;
	logic signed [31:0] i_level_hz, o_level_hz;
	logic [33:0] i_pwr_thresh;
	logic [31:0] i_hz_scale, i_acq_bw_hz, i_rbw_hz, o_hyst_hz, o_bw;
	int n_dec, n_td, n_iv, b_dec, b_td, b_iv;
	int n_ovf = 0;
	int err_total = 0;
	int n_tests = 0;
	int q = 0;

	frequency_edge_trigger dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_smp_valid(i_smp_valid), .i_smp_i(i_smp_i), .i_smp_q(i_smp_q),
		.i_level_hz(i_level_hz), .i_slope_fall(i_slope_fall),
		.i_pwr_thresh(i_pwr_thresh), .i_hz_scale(i_hz_scale),
		.i_acq_bw_hz(i_acq_bw_hz), .i_rbw_en(i_rbw_en), .i_rbw_hz(i_rbw_hz),
		.i_interp_en(i_interp_en), .i_td_match(i_td_match),
		.o_trig_dec(o_trig_dec), .o_trig_td(o_trig_td),
		.o_trig_frac(o_trig_frac),
		.o_hyst_hz(o_hyst_hz), .o_level_hz(o_level_hz),
		.o_trigger_filter_bandwidth(o_bw), .o_pwr_low(o_pwr_low),
		.o_armed(o_armed), .o_interp_valid(o_interp_valid),
		.o_interp_d(o_interp_d), .o_interp_p(o_interp_p),
		.o_fifo_ovf(o_fifo_ovf));

	trig_consumer far (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_trig_dec(o_trig_dec), .i_trig_td(o_trig_td),
		.i_interp_valid(o_interp_valid), .o_n_dec(n_dec), .o_n_td(n_td),
		.o_n_iv(n_iv));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// phasor steps a quarter turn: +1 gives +scale hz, -1 gives -scale hz
	task automatic step(input int d);
		q = (q + d) & 3;
		@(negedge i_clk);
		i_smp_valid = 1'b1;
		i_smp_i = (q == 0) ? 16'sh03E8 : (q == 2) ? -16'sh03E8 : 16'sh0000;
		i_smp_q = (q == 1) ? 16'sh03E8 : (q == 3) ? -16'sh03E8 : 16'sh0000;
		@(negedge i_clk);
		i_smp_valid = 1'b0;
		// overflow pulse stands one cycle: catch it right after the write
		if (o_fifo_ovf === 1'b1) begin
			n_ovf++;
		end
		repeat (3) @(negedge i_clk);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_readout;
		i_level_hz = 32'sh00015F90;
		repeat (3) @(negedge i_clk);
		chk(o_hyst_hz, 34'h7D0);
		chk(o_bw, 34'h186A0);
		chk(o_level_hz, 34'hC350);
		i_rbw_en = 1'b1;
		i_level_hz = -32'sh00015F90;
		repeat (3) @(negedge i_clk);
		chk(o_hyst_hz, 34'h3E8);
		chk(o_bw, 34'hC350);
		chk(o_level_hz, 32'shFFFF9E58);
		i_rbw_en = 1'b0;
		i_level_hz = 32'sh00000000;
		repeat (3) @(negedge i_clk);
		$display("readout test done");
	endtask

	task automatic t_edge(input logic fall, input int d);
		i_slope_fall = fall;
		step(0);
		b_dec = n_dec;
		b_td = n_td;
		step(-d);
		chk(o_armed, 34'h1);
		b_dec = n_dec;
		step(d);
		chk(n_dec - b_dec, 34'h1);
		chk(o_armed, 34'h0);
		chk(n_td - b_td, 34'h1);
		b_dec = n_dec;
		step(d);
		chk(n_dec - b_dec, 34'h0);
		$display("edge test done");
	endtask

	task automatic t_power;
		i_slope_fall = 1'b0;
		i_pwr_thresh = 34'h0001E8480;
		b_td = n_dec;
		step(-1);
		step(1);
		chk(o_pwr_low, 34'h1);
		chk(n_dec - b_td, 34'h0);
		i_pwr_thresh = 34'h000000000;
		$display("power test done");
	endtask

	// -10 khz then +10 khz: level 0 is crossed half way through the pair
	task automatic t_interp;
		int w;
		w = 0;
		i_interp_en = 1'b1;
		i_td_match = 1'b1;
		b_iv = n_iv;
		b_td = n_td;
		b_dec = n_dec;
		step(-1);
		step(1);
		while (o_trig_td !== 1'b1 && w < 100) begin
			@(negedge i_clk);
			w++;
		end
		chk(o_trig_frac, 34'h20);
		chk(o_interp_d, 34'h0);
		chk(o_interp_p, 34'hF4240);
		repeat (40) @(negedge i_clk);
		chk(n_iv - b_iv, 34'h40);
		chk(n_td - b_td, 34'h1);
		chk(n_dec - b_dec, 34'h1);
		// nine writes long before one pair drains: the ninth is lost
		i_td_match = 1'b0;
		i_interp_en = 1'b0;
		repeat (2) @(negedge i_clk);
		i_interp_en = 1'b1;
		b_iv = n_ovf;
		repeat (9) step(0);
		chk(n_ovf - b_iv, 34'h1);
		i_interp_en = 1'b0;
		$display("interpolation test done");
	endtask

	task automatic t_reset;
		step(-1);
		chk(o_armed, 34'h1);
		i_rst_b = 1'b0;
		@(negedge i_clk);
		chk(o_armed, 34'h0);
		chk(o_hyst_hz, 34'h0);
		i_rst_b = 1'b1;
		repeat (2) @(negedge i_clk);
		chk(o_hyst_hz, 34'h7D0);
		$display("reset test done");
	endtask

	// ----------------------------------------
	// clock, reset, sequence, watchdog
	// ----------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	initial begin
		i_rst_b = 1'b0;
		{i_smp_valid, i_slope_fall, i_rbw_en, i_interp_en, i_td_match} = 5'h00;
		i_smp_i = 16'sh03E8;
		i_smp_q = 16'sh0000;
		i_level_hz = 32'sh00000000;
		i_pwr_thresh = 34'h000000000;
		i_hz_scale = 32'h00002710;
		i_acq_bw_hz = 32'h000186A0;
		i_rbw_hz = 32'h0000C350;
		b_dec = 0;
		repeat (16) @(negedge i_clk);
		i_rst_b = 1'b1;
		t_readout();
		t_edge(1'b0, 1);
		t_edge(1'b1, -1);
		t_power();
		t_interp();
		t_reset();
		end_of_test();
	end

	initial begin
		#20000;
		err_total++;
		end_of_test();
	end
endmodule

`default_nettype wire
